// [hdl/fpx_exc_unit.sv]
// exception detection and init state of the floating-point coprocessor
module fpx_exc_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // instruction issue from the host port
   input wire logic issueValid,
   input wire fpx_pkg::fpx_op_t issueOp,
   input wire logic [15:0] writeData,
   input wire fpx_pkg::fpx_dst_t destKind,
   // operands from the datapath
   input wire logic [fpx_pkg::EXP_W-1:0] expA,
   input wire logic [fpx_pkg::SIG_W-1:0] sigA,
   input wire logic [fpx_pkg::EXP_W-1:0] expB,
   input wire logic [fpx_pkg::SIG_W-1:0] sigB,
   input wire logic useB,
   // result conditions from the datapath
   input wire logic indeterminate,
   input wire logic stackFault,
   input wire logic outOfRange,
   input wire logic resultHuge,
   input wire logic resultTiny,
   input wire logic denormLoss,
   input wire logic resultInexact,
   input wire logic premIncomplete,
   input wire logic [3:0] condIn,
   input wire logic [15:0] actualTag,
   // control and state outputs
   output logic [15:0] controlWord,
   output logic [15:0] statusWord,
   output logic [15:0] tagWord,
   output logic [1:0] precisionField,
   output logic [1:0] roundingField,
   output logic roundApply,
   output logic affineMode,
   output fpx_pkg::fpx_rsp_t defaultRsp,
   // handshake toward the host
   output logic busy,
   output logic error_n,
   output logic errorChecked
);
   import fpx_pkg::*;

   logic rstSync1_q;
   logic rstSync_n;
   logic [15:0] cw_q;
   logic [NUM_EXC-1:0] excFlags_q;
   logic stkFault_q;
   logic errSum_q;
   logic [3:0] cc_q;
   logic [2:0] top_q;
   logic [15:0] tag_q;
   logic [15:0] tagNext;
   logic [7:0] busyCnt_q;
   fpx_rsp_t rsp_q;
   logic [1:0] snanV, badV, denV, zeroV, infV;
   logic isInit, isLegacy, isNumeric, isPush, widenOp;
   logic [NUM_EXC-1:0] raised;
   logic [NUM_EXC-1:0] flagsNow;
   logic unmaskedNow;
   fpx_rsp_t rspNow;
   logic [EXP_W-1:0] expSel [2];
   logic [SIG_W-1:0] sigSel [2];

   function automatic logic op_is_init(input fpx_op_t op);
      return op == FPX_INIT || op == FPX_INIT_NW;
   endfunction : op_is_init

   function automatic logic op_is_legacy(input fpx_op_t op);
      return op inside {FPX_ENI, FPX_ENI_NW, FPX_DISI, FPX_DISI_NW};
   endfunction : op_is_legacy

   // reset leaves through two flops so release is clean on ref_clk
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_q <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync_n <= rstSync1_q;
      end
   end

   // instruction decode; the host keeps issues apart by watching busy
   always_comb begin
      isInit = issueValid && op_is_init(issueOp);
      isLegacy = issueValid && op_is_legacy(issueOp);
      isNumeric = issueValid && (issueOp inside {FPX_ARITH, FPX_DIV,
         FPX_LDCONST, FPX_LOAD, FPX_PREM, FPX_SCALE, FPX_PATAN,
         FPX_TWO_POW_MINUS_ONE_INSTR, FPX_PTAN});
      isPush = issueValid && (issueOp inside {FPX_LDCONST, FPX_LOAD});
      widenOp = issueOp inside {FPX_SCALE, FPX_PATAN, FPX_TWO_POW_MINUS_ONE_INSTR,
         FPX_PTAN};
   end

   assign expSel[0] = expA;
   assign expSel[1] = expB;
   assign sigSel[0] = sigA;
   assign sigSel[1] = sigB;

   // one classifier per operand
   for (genvar g = 0; g < 2; g++) begin : gClass
      fpx_opclass uClass (
         .expo(expSel[g]),
         .sig(sigSel[g]),
         .isSnan(snanV[g]),
         .isBadFmt(badV[g]),
         .isDenorm(denV[g]),
         .isZero(zeroV[g]),
         .isInf(infV[g])
      );
   end

   // raw exception conditions of the instruction being issued
   always_comb begin
      raised = '0;
      raised[EX_INV] = (snanV[0] || (useB && snanV[1]) || badV[0]
         || (useB && badV[1]) || indeterminate || stackFault
         || (outOfRange && !widenOp));
      raised[EX_DEN] = denV[0] || (useB && denV[1]);
      raised[EX_ZDV] = issueOp == FPX_DIV && zeroV[1] && !zeroV[0]
         && !infV[0];
      raised[EX_OVF] = resultHuge;
      // masked underflow counts only when denormalizing loses bits
      raised[EX_UNF] = resultTiny
         && (!cw_q[MASK_LSB+EX_UNF] || denormLoss);
      raised[EX_PRE] = resultInexact;
      if (!isNumeric) begin
         raised = '0;
      end
   end

   fpx_prio uPrio (
      .raised(raised),
      .mask(cw_q[MASK_LSB +: NUM_EXC]),
      .dst(destKind),
      .flags(flagsNow),
      .unmasked(unmaskedNow),
      .rsp(rspNow)
   );

   // control word: written by software, reloaded by reset and init
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cw_q <= CW_RESET;
      end else if (isInit) begin
         cw_q <= CW_RESET;
      end else if (issueValid && issueOp == FPX_WRCW) begin
         cw_q <= writeData & CW_WMASK;
      end
   end

   // sticky flags; stack fault rides along with invalid
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         excFlags_q <= '0;
         stkFault_q <= 1'b0;
         errSum_q <= 1'b0;
      end else if (isInit) begin
         excFlags_q <= '0;
         stkFault_q <= 1'b0;
         errSum_q <= 1'b0;
      end else if (isNumeric) begin
         excFlags_q <= excFlags_q | flagsNow;
         stkFault_q <= stkFault_q | (flagsNow[EX_INV] && stackFault);
         errSum_q <= errSum_q | unmaskedNow;
      end
   end

   // condition codes follow the datapath at issue
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cc_q <= '0;
      end else if (isInit) begin
         cc_q <= '0;
      end else if (issueValid && issueOp == FPX_PREM && premIncomplete) begin
         cc_q <= '0;
      end else if (isNumeric) begin
         cc_q <= condIn;
      end
   end

   // stack top moves down on each push without a stack fault, wrapping 0 to 7
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         top_q <= TOP_RESET;
      end else if (isInit) begin
         top_q <= TOP_RESET;
      end else if (isPush && !stackFault) begin
         top_q <= top_q - 3'h1;
      end
   end

   // only the empty code may be forced; others must match contents
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (writeData[2*i +: 2] == TAG_EMPTY
               || writeData[2*i +: 2] == actualTag[2*i +: 2]) begin
            tagNext[2*i +: 2] = writeData[2*i +: 2];
         end else begin
            tagNext[2*i +: 2] = tag_q[2*i +: 2];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         tag_q <= TAG_RESET;
      end else if (isInit) begin
         tag_q <= TAG_RESET;
      end else if (issueValid && issueOp == FPX_WRTAG) begin
         tag_q <= tagNext;
      end else if (isNumeric) begin
         tag_q <= actualTag;
      end
   end

   // busy spans the execution time of a numeric instruction
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         busyCnt_q <= '0;
      end else if (isInit) begin
         busyCnt_q <= '0;
      end else if (isNumeric) begin
         busyCnt_q <= 8'(EXEC_CYC);
      end else if (busyCnt_q != '0) begin
         busyCnt_q <= busyCnt_q - 8'h01;
      end
   end

   // masked default response held for the datapath
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rsp_q <= RSP_NONE;
      end else if (isNumeric || isInit) begin
         rsp_q <= isInit ? RSP_NONE : rspNow;
      end
   end

   // error is checked by the plain no-op but never by legacy no-ops
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         errorChecked <= 1'b0;
      end else begin
         errorChecked <= issueValid && issueOp == FPX_NOP;
      end
   end

   // output views of state
   always_comb begin
      statusWord = '0;
      statusWord[MASK_LSB +: NUM_EXC] = excFlags_q;
      statusWord[SF_BIT] = stkFault_q;
      statusWord[ES_BIT] = errSum_q;
      statusWord[C0_BIT] = cc_q[0];
      statusWord[C1_BIT] = cc_q[1];
      statusWord[C2_BIT] = cc_q[2];
      statusWord[C3_BIT] = cc_q[3];
      statusWord[TOP_LSB +: 3] = top_q;
      statusWord[BUSY_BIT] = busyCnt_q != '0;
   end

   assign controlWord = cw_q;
   assign tagWord = tag_q;
   assign precisionField = cw_q[PREC_LSB +: 2];
   assign roundingField = cw_q[RND_LSB +: 2];
   // constant loads round like any rounding instruction
   assign roundApply = isNumeric && issueOp != FPX_PREM;
   // bit 12 is storage only; closure is always affine
   assign affineMode = 1'b1;
   assign defaultRsp = rsp_q;
   assign busy = busyCnt_q != '0;
   assign error_n = !errSum_q;

   // a sequence: init issued, then state is reloaded one edge later
   sequence s_init;
      issueValid && op_is_init(issueOp);
   endsequence
   sequence s_reloaded;
      cw_q == CW_RESET && tag_q == TAG_RESET && top_q == 3'h0
         && excFlags_q == '0 && cc_q == '0 && !busy;
   endsequence

   property p_init_state;
      @(posedge ref_clk) disable iff (!rstSync_n)
      s_init |=> s_reloaded;
   endproperty
   a_init_state: assert property (p_init_state)
      else $error("init did not restore control/tag/status");

   property p_unmasked_err;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isNumeric && !isInit && unmaskedNow) |=> (!error_n && errSum_q);
   endproperty
   a_unmasked_err: assert property (p_unmasked_err)
      else $error("unmasked exception did not drive error low");

   property p_zdv;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isNumeric && issueOp == FPX_DIV && zeroV[1] && !zeroV[0]
         && !infV[0] && !raised[EX_INV] && !raised[EX_DEN])
         |=> statusWord[EX_ZDV];
   endproperty
   a_zdv: assert property (p_zdv)
      else $error("zero divide not flagged");

   property p_legacy_quiet;
      @(posedge ref_clk) disable iff (!rstSync_n)
      // busy may still count down under a legacy op, so it is left out
      isLegacy |=> ($stable(cw_q) && $stable(statusWord[BUSY_BIT-1:0])
         && !errorChecked);
   endproperty
   a_legacy_quiet: assert property (p_legacy_quiet)
      else $error("legacy no-op changed state or checked error");

   property p_busy_len;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isNumeric && !busy) |=> busy [*4] ##1 !busy;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");

   property p_push_top;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isPush && !stackFault && !isInit) |=> top_q == $past(top_q) - 3'h1;
   endproperty
   a_push_top: assert property (p_push_top)
      else $error("stack top not decremented on push");

   property p_tag_guard;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (issueValid && issueOp == FPX_WRTAG && writeData[1:0] != TAG_EMPTY
         && writeData[1:0] != actualTag[1:0]) |=> $stable(tag_q[1:0]);
   endproperty
   a_tag_guard: assert property (p_tag_guard)
      else $error("illegal tag write accepted");

   property p_inv_first;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isNumeric && raised[EX_INV]) |-> flagsNow[NUM_EXC-1:1] == '0;
   endproperty
   a_inv_first: assert property (p_inv_first)
      else $error("exception reported after invalid");

   property p_unf_masked;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (isNumeric && cw_q[EX_UNF] && resultTiny && !denormLoss)
         |-> !raised[EX_UNF];
   endproperty
   a_unf_masked: assert property (p_unf_masked)
      else $error("masked underflow raised without loss");

   property p_prem_cc;
      @(posedge ref_clk) disable iff (!rstSync_n)
      (issueValid && issueOp == FPX_PREM && premIncomplete)
         |=> cc_q == 4'h0;
   endproperty
   a_prem_cc: assert property (p_prem_cc)
      else $error("condition codes not cleared");
endmodule : fpx_exc_unit

// [inc/fpx_pkg.sv]
// constants, opcodes and response codes for the fpu exception unit
package fpx_pkg;
   // control word layout
   localparam int MASK_LSB = 0;
   localparam int NUM_EXC = 6;
   localparam int PREC_LSB = 8;
   localparam int RND_LSB = 10;
   localparam int INF_BIT = 12;
   localparam logic [15:0] CW_RESET = 16'h037f;
   localparam logic [15:0] CW_WMASK = 16'h1f3f;
   // status word layout
   localparam int SF_BIT = 6;
   localparam int ES_BIT = 7;
   localparam int C0_BIT = 8;
   localparam int C1_BIT = 9;
   localparam int C2_BIT = 10;
   localparam int TOP_LSB = 11;
   localparam int C3_BIT = 14;
   localparam int BUSY_BIT = 15;
   localparam logic [2:0] TOP_RESET = 3'h0;
   localparam logic [15:0] TAG_RESET = 16'hffff;
   localparam logic [1:0] TAG_EMPTY = 2'h3;
   // exception index, also precedence order (0 first)
   localparam int EX_INV = 0;
   localparam int EX_DEN = 1;
   localparam int EX_ZDV = 2;
   localparam int EX_OVF = 3;
   localparam int EX_UNF = 4;
   localparam int EX_PRE = 5;
   // execution time of a numeric instruction
   localparam int EXEC_NS = 16;
   localparam int CLK_PS = 4000;
   localparam int EXEC_CYC = (EXEC_NS * 1000) / CLK_PS;
   localparam int EXP_W = 15;
   localparam int SIG_W = 64;

   typedef enum logic [4:0] {
      FPX_NOP, FPX_INIT, FPX_INIT_NW, FPX_ENI, FPX_ENI_NW, FPX_DISI,
      FPX_DISI_NW, FPX_ARITH, FPX_DIV, FPX_LDCONST, FPX_LOAD, FPX_PREM,
      FPX_SCALE, FPX_PATAN, FPX_TWO_POW_MINUS_ONE_INSTR, FPX_PTAN, FPX_WRCW, FPX_WRTAG
   } fpx_op_t;

   typedef enum logic [2:0] {
      RSP_NONE, RSP_QNAN, RSP_INT_INDEF, RSP_BCD_INDEF, RSP_INF,
      RSP_BIG_OR_INF, RSP_DENORM_ZERO, RSP_NORMALIZE
   } fpx_rsp_t;

   typedef enum logic [1:0] {
      DST_FLOAT, DST_INT, DST_BCD
   } fpx_dst_t;
endpackage : fpx_pkg

// [hdl/fpx_opclass.sv]
// classifies one extended-format operand for exception detection
module fpx_opclass (
   // operand fields
   input wire logic [fpx_pkg::EXP_W-1:0] expo,
   input wire logic [fpx_pkg::SIG_W-1:0] sig,
   // classification
   output logic isSnan,
   output logic isBadFmt,
   output logic isDenorm,
   output logic isZero,
   output logic isInf
);
   import fpx_pkg::*;

   logic expMax;
   logic expMin;
   logic intBit;
   logic fracNz;

   // the explicit integer bit must agree with the exponent class
   always_comb begin
      expMax = &expo;
      expMin = ~|expo;
      intBit = sig[SIG_W-1];
      fracNz = |sig[SIG_W-2:0];
      isZero = expMin && !intBit && !fracNz;
      isDenorm = expMin && !intBit && fracNz;
      isInf = expMax && intBit && !fracNz;
      isSnan = expMax && intBit && !sig[SIG_W-2] && fracNz;
      // pseudo-nan, pseudo-infinity, unnormal, pseudozero and pseudo-denormal forms
      isBadFmt = (expMax && !intBit) || (!expMin && !expMax && !intBit)
         || (expMin && intBit);
   end
endmodule : fpx_opclass

// [hdl/fpx_prio.sv]
// orders raised exceptions and picks the masked default response
module fpx_prio (
   // raw exceptions and masks
   input wire logic [fpx_pkg::NUM_EXC-1:0] raised,
   input wire logic [fpx_pkg::NUM_EXC-1:0] mask,
   input wire fpx_pkg::fpx_dst_t dst,
   // outcome
   output logic [fpx_pkg::NUM_EXC-1:0] flags,
   output logic unmasked,
   output fpx_pkg::fpx_rsp_t rsp
);
   import fpx_pkg::*;

   logic stop;

   // walk in precedence order; an unmasked one, invalid or zero-divide
   // ends the instruction so nothing later is reported
   always_comb begin
      flags = '0;
      unmasked = 1'b0;
      rsp = RSP_NONE;
      stop = 1'b0;
      for (int i = 0; i < NUM_EXC; i++) begin
         if (raised[i] && !stop) begin
            flags[i] = 1'b1;
            if (!mask[i]) begin
               unmasked = 1'b1;
               stop = 1'b1;
            end
            if (i == EX_INV || i == EX_ZDV) begin
               stop = 1'b1;
            end
            if (mask[i] && rsp == RSP_NONE) begin
               unique case (i)
                  EX_INV: rsp = (dst == DST_INT) ? RSP_INT_INDEF :
                     (dst == DST_BCD) ? RSP_BCD_INDEF : RSP_QNAN;
                  EX_DEN: rsp = RSP_NORMALIZE;
                  EX_ZDV: rsp = RSP_INF;
                  EX_OVF: rsp = RSP_BIG_OR_INF;
                  EX_UNF: rsp = RSP_DENORM_ZERO;
                  default: rsp = RSP_NONE;
               endcase
            end
         end
      end
   end
endmodule : fpx_prio

// [test/fpx_host_model.sv]
// host cpu model: issues instructions and honours the busy handshake
module fpx_host_model (
   // clock and handshake
   input wire logic ref_clk,
   input wire logic busy,
   // issue port
   output fpx_pkg::fpx_op_t issueOp,
   output logic issueValid
);
   timeunit 1ns;
   timeprecision 1ps;
   import fpx_pkg::*;

   // idle port at time zero
   initial begin
      issueValid = 1'b0;
      issueOp = FPX_NOP;
   end

   // processor control ops need no busy wait
   function automatic bit isCtrl(input fpx_op_t op);
      return op inside {FPX_NOP, FPX_INIT, FPX_INIT_NW, FPX_ENI, FPX_ENI_NW,
         FPX_DISI, FPX_DISI_NW, FPX_WRCW, FPX_WRTAG};
   endfunction : isCtrl

   // one-cycle issue pulse, raised and dropped on the falling edge
   task automatic run(input fpx_op_t op);
      int guard;
      guard = 0;
      @(negedge ref_clk);
      // guard keeps a stuck busy from hanging the host
      while (busy !== 1'b0 && !isCtrl(op) && guard < 100) begin
         @(negedge ref_clk);
         guard++;
      end
      // a busy that never drops is counted against the run
      if (guard >= 100) begin
         testbench.err_count++;
         $display("CHECK FAILED %0t busy never dropped", $time);
      end
      issueOp = op;
      issueValid = 1'b1;
      @(negedge ref_clk);
      issueValid = 1'b0;
   endtask : run
endmodule : fpx_host_model

// [test/testbench.sv]
// self-checking bench for the fpu exception unit
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fpx_pkg::*;

   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic issueValid, useB, indeterminate, stackFault, outOfRange;
   logic resultHuge, resultTiny, denormLoss, resultInexact, premIncomplete;
   logic busy, error_n, errorChecked, roundApply, affineMode, lastRound;
   logic [15:0] writeData, actualTag, controlWord, statusWord, tagWord;
   logic [14:0] expA, expB;
   logic [63:0] sigA, sigB;
   logic [3:0] condIn;
   logic [1:0] precisionField, roundingField;
   fpx_op_t issueOp;
   fpx_dst_t destKind;
   fpx_rsp_t defaultRsp;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int ecCount = 0;

   fpx_exc_unit i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .issueValid(issueValid), .issueOp(issueOp), .writeData(writeData),
      .destKind(destKind), .expA(expA), .sigA(sigA), .expB(expB),
      .sigB(sigB), .useB(useB), .indeterminate(indeterminate),
      .stackFault(stackFault), .outOfRange(outOfRange),
      .resultHuge(resultHuge), .resultTiny(resultTiny),
      .denormLoss(denormLoss), .resultInexact(resultInexact),
      .premIncomplete(premIncomplete), .condIn(condIn),
      .actualTag(actualTag), .controlWord(controlWord),
      .statusWord(statusWord), .tagWord(tagWord),
      .precisionField(precisionField), .roundingField(roundingField),
      .roundApply(roundApply), .affineMode(affineMode),
      .defaultRsp(defaultRsp), .busy(busy), .error_n(error_n),
      .errorChecked(errorChecked));

   fpx_host_model i_host (.ref_clk(ref_clk), .busy(busy),
      .issueOp(issueOp), .issueValid(issueValid));

   // 250 mhz clock
   always #2 ref_clk = ~ref_clk;

   // timeout, rounding capture at issue and error-check pulse count
   always @(posedge ref_clk) begin
      cyc++;
      if (issueValid === 1'b1) lastRound = roundApply;
      if (errorChecked === 1'b1) ecCount++;
      if (cyc == 20000) begin
         err_count++;
         $display("CHECK FAILED %0t run timed out", $time);
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string msg);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // quiet operands: normal values, no result conditions
   task automatic clr();
      {useB, indeterminate, stackFault, outOfRange, resultHuge} = '0;
      {resultTiny, denormLoss, resultInexact, premIncomplete} = '0;
      expA = 15'h3fff;
      expB = 15'h3fff;
      sigA = 64'h8000_0000_0000_0000;
      sigB = 64'h8000_0000_0000_0000;
      condIn = 4'h0;
      writeData = 16'h0000;
      actualTag = 16'hffff;
      destKind = DST_FLOAT;
   endtask : clr

   // wait out any busy period, then re-initialize
   task automatic fresh();
      repeat (6) @(negedge ref_clk);
      clr();
      i_host.run(FPX_INIT_NW);
   endtask : fresh

   task automatic init_state(input string msg);
      chk(controlWord, 16'h037f, msg);
      chk(statusWord, 16'h0000, msg);
      chk(tagWord, 16'hffff, msg);
      chk({error_n, busy, affineMode}, 3'h5, msg);
   endtask : init_state

   task automatic s_zdiv();
      fresh();
      useB = 1'b1;
      expB = 15'h0000;
      sigB = 64'h0;
      i_host.run(FPX_DIV);
      chk(statusWord[7:0], 8'h04, "zdiv flags");
      chk({error_n, busy}, 2'h3, "zdiv hs");
      chk(16'(defaultRsp), 16'(RSP_INF), "zdiv rsp");
      repeat (3) @(negedge ref_clk);
      chk(16'(busy), 16'h1, "busy held");
      @(negedge ref_clk);
      chk(16'(busy), 16'h0, "busy end");
   endtask : s_zdiv

   task automatic s_invalid();
      fresh();
      sigA = 64'h8000_0000_0000_0001;
      expA = 15'h7fff;
      resultInexact = 1'b1;
      destKind = DST_INT;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h01, "snan");
      chk(16'(defaultRsp), 16'(RSP_INT_INDEF), "int indef");
      fresh();
      stackFault = 1'b1;
      destKind = DST_BCD;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h41, "stack fault");
      chk(16'(defaultRsp), 16'(RSP_BCD_INDEF), "bcd indef");
      fresh();
      sigA = 64'h4000_0000_0000_0000;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h01, "unnormal");
      chk(16'(defaultRsp), 16'(RSP_QNAN), "qnan");
      fresh();
      expA = 15'h0000;
      sigA = 64'h1;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h02, "denorm");
      chk(16'(defaultRsp), 16'(RSP_NORMALIZE), "normalize");
   endtask : s_invalid

   task automatic s_range();
      fpx_op_t ops[4] = '{FPX_SCALE, FPX_PATAN, FPX_TWO_POW_MINUS_ONE_INSTR, FPX_PTAN};
      foreach (ops[i]) begin
         fresh();
         outOfRange = 1'b1;
         i_host.run(ops[i]);
         chk(statusWord[7:0], 8'h00, "wide range");
      end
      fresh();
      outOfRange = 1'b1;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h01, "out of range");
   endtask : s_range

   task automatic s_masked();
      fresh();
      resultTiny = 1'b1;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h00, "tiny exact");
      fresh();
      {resultTiny, denormLoss} = 2'h3;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h10, "tiny loss");
      chk(16'(defaultRsp), 16'(RSP_DENORM_ZERO), "dnz");
      fresh();
      resultHuge = 1'b1;
      i_host.run(FPX_ARITH);
      chk(statusWord[7:0], 8'h08, "ovf masked");
      chk(16'(defaultRsp), 16'(RSP_BIG_OR_INF), "big");
      fresh();
      resultInexact = 1'b1;
      i_host.run(FPX_ARITH);
      chk({error_n, statusWord[7:0]}, 9'h120, "inexact");
   endtask : s_masked

   task automatic s_unmask();
      fresh();
      writeData = 16'hfb40;
      i_host.run(FPX_WRCW);
      chk(controlWord, 16'h1b00, "cw write");
      chk({precisionField, roundingField}, 4'he, "fields");
      chk(16'(affineMode), 16'h1, "affine");
      resultHuge = 1'b1;
      i_host.run(FPX_ARITH);
      chk({error_n, statusWord[7:0]}, 9'h088, "ovf unmasked");
      clr();
      ecCount = 0;
      for (int i = 0; i < 4; i++) begin
         i_host.run(fpx_op_t'(int'(FPX_ENI) + i));
         chk(statusWord[7:0], 8'h88, "legacy sw");
         chk(controlWord, 16'h1b00, "legacy cw");
      end
      chk(16'(ecCount), 16'h0, "legacy no check");
      i_host.run(FPX_NOP);
      @(negedge ref_clk);
      chk(16'(ecCount), 16'h1, "nop checks");
      i_host.run(FPX_INIT);
      init_state("reinit");
   endtask : s_unmask

   task automatic s_stack();
      fresh();
      lastRound = 1'b0;
      i_host.run(FPX_LDCONST);
      chk(16'(lastRound), 16'h1, "const rounds");
      chk(16'(statusWord[13:11]), 16'h7, "first push");
      // a faulting load must not move the stack top
      stackFault = 1'b1;
      i_host.run(FPX_LOAD);
      chk(statusWord & 16'h38ff, 16'h3841, "load fault");
      stackFault = 1'b0;
      condIn = 4'hf;
      i_host.run(FPX_ARITH);
      chk(statusWord & 16'h4700, 16'h4700, "cc set");
      premIncomplete = 1'b1;
      i_host.run(FPX_PREM);
      chk(16'(lastRound), 16'h0, "prem no round");
      chk(statusWord & 16'h4700, 16'h0000, "cc cleared");
      fresh();
      actualTag = 16'h0000;
      writeData = 16'h0000;
      i_host.run(FPX_WRTAG);
      chk(tagWord, 16'h0000, "tag match");
      // entry 0 asks for a non-empty code unlike its contents, entry 1 empty
      writeData = 16'h000d;
      i_host.run(FPX_WRTAG);
      chk(tagWord, 16'h000c, "tag refuse");
   endtask : s_stack

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // reset, recommended init, then the scenarios
   initial begin
      clr();
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      init_state("reset");
      i_host.run(FPX_INIT_NW);
      init_state("init");
      s_zdiv();
      s_invalid();
      s_range();
      s_masked();
      s_unmask();
      s_stack();
      complete_run();
   end
endmodule : testbench
